// >>> pfm_far_model.sv
// far side of the pads: pad wiring, bench-driven levels, slow memory ready
// assumes extIn comes from the bench for every pad the mux leaves undriven except pad 24, which this model drives as ready
module pfm_far_model (
    input wire clock,
    input wire [71:0] padOut,
    input wire [71:0] padOe,
    input wire [71:0] extIn,
    input wire accessStart,
    input wire slow,
    output logic [71:0] padIn
);
    logic [1:0] holdCnt_r = 2'h0;
    // slow memory pulls ready low in the access cycle and three more
    // ready must already be low at the edge that starts the access, since the mux samples it there
    always @(posedge clock) begin
        if (accessStart && slow)
            holdCnt_r <= 2'h3;
        else if (holdCnt_r != 2'h0)
            holdCnt_r <= holdCnt_r - 2'h1;
    end
    always_comb begin
        padIn = extIn;
        padIn[24] = !(accessStart && slow) && (holdCnt_r == 2'h0);
        for (int i = 0; i < 72; i++)
            if (padOe[i])
                padIn[i] = padOut[i];
    end
endmodule

// >>> pfm_map.vh
// offsets, field positions, reset values and timing figures of the pin function mux
// assumes inclusion by bare name from the design files
`ifndef PFM_MAP_VH
`define PFM_MAP_VH
`define PFM_OFS_DIR 8'h00
`define PFM_OFS_DATA 8'h10
`define PFM_OFS_PIN 8'h20
`define PFM_OFS_SLEW 8'h30
`define PFM_OFS_CTRL0 8'h40
`define PFM_OFS_CTRL1 8'h41
`define PFM_OFS_KEYMASK 8'h42
`define PFM_OFS_STATUS 8'h43
`define PFM_CTRL0_MODE_LSB 0
`define PFM_CTRL0_WAIT_LSB 2
`define PFM_CTRL0_EXTENDED_DATA_ACCESS 4
`define PFM_CTRL0_HOST 5
`define PFM_CTRL0_SOF 6
`define PFM_CTRL0_T1 7
`define PFM_CTRL1_IRQ0POL 0
`define PFM_CTRL1_IRQ1POL 1
`define PFM_CTRL1_TXPOL 2
`define PFM_CTRL1_TYPOL 3
`define PFM_CTRL1_T1INIT 4
`define PFM_CTRL1_UART2 5
`define PFM_CTRL1_SIO 6
`define PFM_CTRL1_YIELD 7
`define PFM_MODE_SINGLE 2'h0
`define PFM_MODE_EXPAND 2'h1
`define PFM_MODE_MICRO 2'h2
`define PFM_MODE_PROM 2'h3
`define PFM_WAIT_NONE 2'h0
`define PFM_WAIT_SOFT 2'h1
`define PFM_WAIT_RDY 2'h2
`define PFM_WAIT_EXTRDY 2'h3
`define PFM_DIR_RST 8'h00
`define PFM_DATA_RST 8'h00
`define PFM_SLEW_RST 8'h00
`define PFM_CTRL0_RST 8'h00
`define PFM_CTRL1_RST 8'h00
`define PFM_KEYMASK_RST 8'h00
`define PFM_SOF_PULSE_NS 80
`define PFM_CLK_MHZ 100
`endif

// >>> pfm_mux_chk.sv
// port checker for the pin function mux
// assumes a bind onto pfm_pin_function_mux with its NPORT
module pfm_mux_chk #(parameter NPORT = 9) (
    input wire clock,
    input wire rst,
    input wire regWr,
    input wire regRd,
    input wire [7:0] regRdData,
    input wire [NPORT*8-1:0] padIn,
    input wire [NPORT*8-1:0] padOut,
    input wire [NPORT*8-1:0] padOe,
    input wire [15:0] cpuAddr,
    input wire cpuAccessStart,
    input wire busWait,
    input wire keyWake,
    input wire extIrqZero,
    input wire timerXOutMode,
    input wire timerXIn,
    input wire timerXIrq,
    input wire timerYOutMode,
    input wire timerYIrq,
    input wire usbFrameStart
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_rd; !$past(regRd) |-> regRdData == 8'h00; endproperty
    a_rd: assert property (p_rd) else $error("read data outside slot");
    property p_rst; $fell(rst) |-> padOe == '0 && padOut == '0; endproperty
    a_rst: assert property (p_rst) else $error("pads driven after reset");
    // address pads may only move on their own as the cpu address
    property p_adr;
        !$past(regWr, 2) && $changed(padOut[15:0]) |-> padOut[15:0] == $past(cpuAddr);
    endproperty
    a_adr: assert property (p_adr) else $error("address pads wrong");
    property p_sof;
        $rose(padOut[56]) && $past(usbFrameStart, 2) |-> padOut[56] [*8] ##1 !padOut[56];
    endproperty
    a_sof: assert property (p_sof) else $error("frame pulse width");
    property p_wup; $rose(busWait) |-> $past(cpuAccessStart, 2); endproperty
    a_wup: assert property (p_wup) else $error("wait without access");
    property p_wdn;
        $fell(busWait) |-> $past(padIn[24], 2) || $past(cpuAccessStart, 3);
    endproperty
    a_wdn: assert property (p_wdn) else $error("wait ended early");
    property p_key; padIn[23:16] == 8'hFF [*3] |-> !keyWake; endproperty
    a_key: assert property (p_key) else $error("wake with pins high");
    property p_irq;
        (!regWr && $stable(padIn[33])) [*3] |=> $stable(extIrqZero);
    endproperty
    a_irq: assert property (p_irq) else $error("irq moved alone");
    property p_tx; timerXOutMode [*2] |-> !timerXIrq && !timerXIn; endproperty
    a_tx: assert property (p_tx) else $error("timer x input in out mode");
    property p_ty; timerYOutMode [*2] |-> !timerYIrq; endproperty
    a_ty: assert property (p_ty) else $error("timer y irq in out mode");
    c_sof: cover property ($rose(padOut[56]));
    c_wait: cover property ($rose(busWait));
    c_rd: cover property (regRd ##1 regRdData != 8'h00);
endmodule
bind pfm_pin_function_mux pfm_mux_chk #(.NPORT(NPORT)) u_chk (.*);

// >>> pfm_pin_function_mux.v
// pin function mux: gpio ports with alternate functions and a small register port
// assumes pad inputs are synchronous and pads are resolved outside from out and oe
// Operation
// - expanded modes drive ports 0-1 as address
// - expanded modes use port 2 as data bus
// - port 2 pins give key-on wake-up
// - ready pin stretches external accesses with waits
// - transfer-active pin high during dma transfer in expanded modes
// - fetch sync and clock out in expanded modes
// - prom controls or write/read strobes on port 3
// - extended data access output in expanded modes
// - extended access only for indirect-indexed load/store
// - two irq pins with selectable active level
// - timer x pin input, output, or irq
// - timer y pin input or output by mode
// - timer y pin irq with its polarity
// - timer 1 output has selectable starting level
// - host buffer 0 select, register select, strobes
// - host buffer 1 select and full flags out
// - buffer-1 flag beats bus-yield ack on pin
// - second uart beats clocked serial on pins
// - frame pin pulses 80 ns each frame
// - host interface uses seventeen signals total
// - per-pin direction and slew rate control
// - software, ready and extended ready waits
//
// Decided for this implementation: the register addresses and strobed register access.
module pfm_pin_function_mux #(
    parameter NPORT = 9
) (
    input wire clock,
    input wire rst,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdData,
    input wire [NPORT*8-1:0] padIn,
    output reg [NPORT*8-1:0] padOut,
    output reg [NPORT*8-1:0] padOe,
    output reg [NPORT*8-1:0] padSlew,
    input wire [15:0] cpuAddr,
    input wire [7:0] cpuWrData,
    input wire cpuWrEn,
    input wire cpuWrN,
    input wire cpuRdN,
    input wire cpuAccessStart,
    input wire cpuIndYLoadStore,
    input wire cpuBeyond64k,
    input wire fetchSync,
    input wire dmaActive,
    output reg [7:0] cpuRdData,
    output reg busWait,
    output reg keyWake,
    output reg promVerify,
    output reg promProgramStrobeN,
    output reg promChipEnableN,
    output reg promOutputEnableN,
    output reg extIrqZero,
    output reg extIrqOne,
    input wire timerXOutMode,
    input wire timerXOut,
    output reg timerXIn,
    output reg timerXIrq,
    input wire timerYOutMode,
    input wire timerYOut,
    output reg timerYIn,
    output reg timerYIrq,
    input wire timer1Toggle,
    input wire hostOutFullZero,
    input wire hostInFullZeroN,
    input wire hostOutFullOne,
    input wire hostInFullOneN,
    input wire [7:0] hostRdData,
    output reg [7:0] hostWrData,
    output reg hostBufferZeroSelectN,
    output reg hostBufferOneSelectN,
    output reg hostRegisterSelect,
    output reg hostReadN,
    output reg hostWriteN,
    input wire busYieldAck,
    output reg holdReq,
    input wire usbFrameStart,
    input wire secondUartTx,
    input wire secondUartRequestToSend,
    output reg secondUartRx,
    output reg secondUartClearToSend,
    input wire clockedSerialReadyOut,
    input wire clockedSerialReadyOe,
    input wire clockedSerialClkOut,
    input wire clockedSerialClkOe,
    input wire clockedSerialTx,
    output reg clockedSerialReadyIn,
    output reg clockedSerialClkIn,
    output reg clockedSerialRx
);
`include "pfm_map.vh"
    localparam NPIN = NPORT * 8;
    // pin positions: port * 8 + bit
    localparam P30 = 24;
    localparam P32 = 26;
    localparam P33 = 27;
    localparam P34 = 28;
    localparam P35 = 29;
    localparam P36 = 30;
    localparam P37 = 31;
    localparam P40 = 32;
    localparam P41 = 33;
    localparam P42 = 34;
    localparam P43 = 35;
    localparam P44 = 36;
    localparam P51 = 41;
    localparam P52 = 42;
    localparam P53 = 43;
    localparam P54 = 44;
    localparam P55 = 45;
    localparam P56 = 46;
    localparam P57 = 47;
    localparam P60 = 48;
    localparam P70 = 56;
    localparam P71 = 57;
    localparam P72 = 58;
    localparam P73 = 59;
    localparam P74 = 60;
    localparam P80 = 64;
    localparam P81 = 65;
    localparam P82 = 66;
    localparam P83 = 67;
    localparam SOF_CYC_RAW = (`PFM_SOF_PULSE_NS * `PFM_CLK_MHZ) / 1000;
    localparam [7:0] SOF_CYC = (SOF_CYC_RAW < 1) ? 8'h01 : SOF_CYC_RAW[7:0];

    function inBank;
        input [7:0] addr;
        input [7:0] base;
        begin
            inBank = (addr[7:4] == base[7:4]) && (addr[3:0] < NPORT);
        end
    endfunction

    reg [NPIN-1:0] dir_r;
    reg [NPIN-1:0] data_r;
    reg [7:0] ctrl0_r;
    reg [7:0] ctrl1_r;
    reg [7:0] keyMask_r;
    reg t1Level_r;
    reg phiToggle_r;
    reg [NPIN-1:0] padOut_nxt;
    reg [NPIN-1:0] padOe_nxt;
    reg [7:0] regRdData_nxt;
    wire waitOut;
    wire sofPulse;
    wire [1:0] procMode = ctrl0_r[`PFM_CTRL0_MODE_LSB+1:`PFM_CTRL0_MODE_LSB];
    wire expanded = (procMode == `PFM_MODE_EXPAND) || (procMode == `PFM_MODE_MICRO);
    wire promMode = (procMode == `PFM_MODE_PROM);
    wire hostEn = ctrl0_r[`PFM_CTRL0_HOST];
    wire uart2En = ctrl1_r[`PFM_CTRL1_UART2];
    wire sioOwns = ctrl1_r[`PFM_CTRL1_SIO] & ~uart2En;
    wire edmaOn = expanded & ctrl0_r[`PFM_CTRL0_EXTENDED_DATA_ACCESS];
    wire hostDrive = hostEn & ~padIn[P56] & (~padIn[P54] | ~padIn[P72]);

    genvar gi;
    generate
        for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_port
            always @(posedge clock) begin
                if (rst) begin
                    dir_r[gi*8+7:gi*8] <= `PFM_DIR_RST;
                    data_r[gi*8+7:gi*8] <= `PFM_DATA_RST;
                    padSlew[gi*8+7:gi*8] <= `PFM_SLEW_RST;
                end else if (regWr) begin
                    if (regAddr == (`PFM_OFS_DIR + gi)) begin
                        dir_r[gi*8+7:gi*8] <= regWrData;
                    end
                    if (regAddr == (`PFM_OFS_DATA + gi)) begin
                        data_r[gi*8+7:gi*8] <= regWrData;
                    end
                    if (regAddr == (`PFM_OFS_SLEW + gi)) begin
                        padSlew[gi*8+7:gi*8] <= regWrData;
                    end
                end
            end
        end
    endgenerate

    always @(posedge clock) begin
        if (rst) begin
            ctrl0_r <= `PFM_CTRL0_RST;
            ctrl1_r <= `PFM_CTRL1_RST;
            keyMask_r <= `PFM_KEYMASK_RST;
        end else if (regWr) begin
            if (regAddr == `PFM_OFS_CTRL0) begin
                ctrl0_r <= regWrData;
            end
            if (regAddr == `PFM_OFS_CTRL1) begin
                ctrl1_r <= regWrData;
            end
            if (regAddr == `PFM_OFS_KEYMASK) begin
                keyMask_r <= regWrData;
            end
        end
    end

    // read data stand only in the cycle after the strobe
    always @* begin
        regRdData_nxt = 8'h00;
        if (regRd) begin
            if (inBank(regAddr, `PFM_OFS_DIR)) begin
                regRdData_nxt = dir_r[regAddr[3:0]*8 +: 8];
            end else if (inBank(regAddr, `PFM_OFS_DATA)) begin
                regRdData_nxt = data_r[regAddr[3:0]*8 +: 8];
            end else if (inBank(regAddr, `PFM_OFS_PIN)) begin
                regRdData_nxt = padIn[regAddr[3:0]*8 +: 8];
            end else if (inBank(regAddr, `PFM_OFS_SLEW)) begin
                regRdData_nxt = padSlew[regAddr[3:0]*8 +: 8];
            end else if (regAddr == `PFM_OFS_CTRL0) begin
                regRdData_nxt = ctrl0_r;
            end else if (regAddr == `PFM_OFS_CTRL1) begin
                regRdData_nxt = ctrl1_r;
            end else if (regAddr == `PFM_OFS_KEYMASK) begin
                regRdData_nxt = keyMask_r;
            end else if (regAddr == `PFM_OFS_STATUS) begin
                regRdData_nxt = {expanded, holdReq, timerYIrq, timerXIrq,
                                 extIrqOne, extIrqZero, keyWake, busWait};
            end
        end
    end

    // pin ownership; later assignments override earlier ones
    always @* begin
        padOut_nxt = data_r;
        padOe_nxt = dir_r;
        if (expanded) begin
            padOut_nxt[15:0] = cpuAddr;
            padOe_nxt[15:0] = 16'hFFFF;
            padOut_nxt[23:16] = cpuWrData;
            padOe_nxt[23:16] = {8{cpuWrEn}};
            padOe_nxt[P30] = 1'b0;
            padOut_nxt[P33] = dmaActive;
            padOe_nxt[P33] = 1'b1;
            padOut_nxt[P34] = phiToggle_r;
            padOe_nxt[P34] = 1'b1;
            padOut_nxt[P35] = fetchSync;
            padOe_nxt[P35] = 1'b1;
            padOut_nxt[P36] = cpuWrN;
            padOe_nxt[P36] = 1'b1;
            padOut_nxt[P37] = cpuRdN;
            padOe_nxt[P37] = 1'b1;
            if (edmaOn) begin
                padOut_nxt[P40] = cpuIndYLoadStore & cpuBeyond64k;
                padOe_nxt[P40] = 1'b1;
            end
        end else if (promMode) begin
            padOe_nxt[P32] = 1'b0;
            padOe_nxt[P33] = 1'b0;
            padOe_nxt[P36] = 1'b0;
            padOe_nxt[P37] = 1'b0;
        end
        if (timerXOutMode) begin
            padOut_nxt[P43] = timerXOut;
            padOe_nxt[P43] = 1'b1;
        end
        if (timerYOutMode) begin
            padOut_nxt[P44] = timerYOut;
            padOe_nxt[P44] = 1'b1;
        end
        if (ctrl0_r[`PFM_CTRL0_T1]) begin
            padOut_nxt[P51] = t1Level_r;
            padOe_nxt[P51] = 1'b1;
        end
        if (hostEn) begin
            padOut_nxt[P52] = hostOutFullZero;
            padOe_nxt[P52] = 1'b1;
            padOut_nxt[P53] = hostInFullZeroN;
            padOe_nxt[P53] = 1'b1;
            padOe_nxt[P57:P54] = 4'h0;
            padOut_nxt[P60+7:P60] = hostRdData;
            padOe_nxt[P60+7:P60] = {8{hostDrive}};
            padOe_nxt[P72] = 1'b0;
            padOut_nxt[P73] = hostInFullOneN;
            padOe_nxt[P73] = 1'b1;
            padOut_nxt[P74] = hostOutFullOne;
            padOe_nxt[P74] = 1'b1;
        end else if (ctrl1_r[`PFM_CTRL1_YIELD]) begin
            padOut_nxt[P73] = busYieldAck;
            padOe_nxt[P73] = 1'b1;
        end
        if (ctrl0_r[`PFM_CTRL0_SOF]) begin
            padOut_nxt[P70] = sofPulse;
            padOe_nxt[P70] = 1'b1;
        end
        if (uart2En) begin
            padOut_nxt[P80] = secondUartTx;
            padOe_nxt[P80] = 1'b1;
            padOe_nxt[P81] = 1'b0;
            padOe_nxt[P82] = 1'b0;
            padOut_nxt[P83] = secondUartRequestToSend;
            padOe_nxt[P83] = 1'b1;
        end else if (sioOwns) begin
            padOut_nxt[P80] = clockedSerialReadyOut;
            padOe_nxt[P80] = clockedSerialReadyOe;
            padOut_nxt[P81] = clockedSerialClkOut;
            padOe_nxt[P81] = clockedSerialClkOe;
            padOe_nxt[P82] = 1'b0;
            padOut_nxt[P83] = clockedSerialTx;
            padOe_nxt[P83] = 1'b1;
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            padOut <= {NPIN{1'b0}};
            padOe <= {NPIN{1'b0}};
            regRdData <= 8'h00;
            t1Level_r <= 1'b0;
            phiToggle_r <= 1'b0;
            cpuRdData <= 8'h00;
            keyWake <= 1'b0;
            promVerify <= 1'b0;
            promProgramStrobeN <= 1'b1;
            promChipEnableN <= 1'b1;
            promOutputEnableN <= 1'b1;
            extIrqZero <= 1'b0;
            extIrqOne <= 1'b0;
            timerXIn <= 1'b0;
            timerXIrq <= 1'b0;
            timerYIn <= 1'b0;
            timerYIrq <= 1'b0;
            hostWrData <= 8'h00;
            hostBufferZeroSelectN <= 1'b1;
            hostBufferOneSelectN <= 1'b1;
            hostRegisterSelect <= 1'b0;
            hostReadN <= 1'b1;
            hostWriteN <= 1'b1;
            holdReq <= 1'b0;
            secondUartRx <= 1'b1;
            secondUartClearToSend <= 1'b1;
            clockedSerialReadyIn <= 1'b0;
            clockedSerialClkIn <= 1'b0;
            clockedSerialRx <= 1'b1;
        end else begin
            padOut <= padOut_nxt;
            padOe <= padOe_nxt;
            regRdData <= regRdData_nxt;
            // phi out runs at half the block clock; the core clock itself cannot leave a flop
            phiToggle_r <= ~phiToggle_r;
            if (!ctrl0_r[`PFM_CTRL0_T1]) begin
                t1Level_r <= ctrl1_r[`PFM_CTRL1_T1INIT];
            end else if (timer1Toggle) begin
                t1Level_r <= ~t1Level_r;
            end
            cpuRdData <= padIn[23:16];
            keyWake <= |(keyMask_r & ~padIn[23:16]);
            promVerify <= promMode & padIn[P32];
            promProgramStrobeN <= ~promMode | padIn[P33];
            promChipEnableN <= ~promMode | padIn[P36];
            promOutputEnableN <= ~promMode | padIn[P37];
            extIrqZero <= ~(padIn[P41] ^ ctrl1_r[`PFM_CTRL1_IRQ0POL]);
            extIrqOne <= ~(padIn[P42] ^ ctrl1_r[`PFM_CTRL1_IRQ1POL]);
            timerXIn <= ~timerXOutMode & padIn[P43];
            timerXIrq <= ~timerXOutMode
                         & ~(padIn[P43] ^ ctrl1_r[`PFM_CTRL1_TXPOL]);
            timerYIn <= ~timerYOutMode & padIn[P44];
            timerYIrq <= ~timerYOutMode
                         & ~(padIn[P44] ^ ctrl1_r[`PFM_CTRL1_TYPOL]);
            hostWrData <= padIn[P60+7:P60];
            hostBufferZeroSelectN <= ~hostEn | padIn[P54];
            hostRegisterSelect <= hostEn & padIn[P55];
            hostReadN <= ~hostEn | padIn[P56];
            hostWriteN <= ~hostEn | padIn[P57];
            hostBufferOneSelectN <= ~hostEn | padIn[P72];
            holdReq <= padIn[P71];
            secondUartRx <= ~uart2En | padIn[P81];
            secondUartClearToSend <= ~uart2En | padIn[P82];
            clockedSerialReadyIn <= sioOwns & padIn[P80];
            clockedSerialClkIn <= sioOwns & padIn[P81];
            clockedSerialRx <= ~sioOwns | padIn[P82];
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            busWait <= 1'b0;
        end else begin
            busWait <= waitOut & expanded;
        end
    end

    pfm_wait_ctl u_wait (
        .clock(clock),
        .rst(rst),
        .scheme(ctrl0_r[`PFM_CTRL0_WAIT_LSB+1:`PFM_CTRL0_WAIT_LSB]),
        .accessStart(cpuAccessStart & expanded),
        .readyIn(~expanded | padIn[P30]),
        .busWait(waitOut)
    );

    pfm_pulse_gen #(
        .PULSE_CYCLES(SOF_CYC)
    ) u_sof (
        .clock(clock),
        .rst(rst),
        .trig(usbFrameStart & ctrl0_r[`PFM_CTRL0_SOF]),
        .pulse(sofPulse)
    );
endmodule

// >>> pfm_pulse_gen.v
// fixed-width pulse stretcher for the frame marker pin
// assumes trig is a one-cycle pulse; a retrigger restarts the count
module pfm_pulse_gen #(
    parameter [7:0] PULSE_CYCLES = 8'h08
) (
    input wire clock,
    input wire rst,
    input wire trig,
    output reg pulse
);
    reg [7:0] count_r;
    always @(posedge clock) begin
        if (rst) begin
            count_r <= 8'h00;
            pulse <= 1'b0;
        end else if (trig) begin
            count_r <= PULSE_CYCLES - 8'h01;
            pulse <= 1'b1;
        end else if (count_r != 8'h00) begin
            count_r <= count_r - 8'h01;
        end else begin
            pulse <= 1'b0;
        end
    end
endmodule

// >>> pfm_wait_ctl.v
// slow memory wait generator for the external bus
// assumes accessStart is a one-cycle pulse from the cpu and readyIn is synchronous
module pfm_wait_ctl (
    input wire clock,
    input wire rst,
    input wire [1:0] scheme,
    input wire accessStart,
    input wire readyIn,
    output reg busWait
);
`include "pfm_map.vh"
    localparam ST_IDLE = 2'h0;
    localparam ST_HOLD = 2'h1;
    localparam ST_EXTRA = 2'h2;
    reg [1:0] state_r;
    always @(posedge clock) begin
        if (rst) begin
            state_r <= ST_IDLE;
            busWait <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (accessStart) begin
                        case (scheme)
                            `PFM_WAIT_SOFT: begin
                                busWait <= 1'b1;
                                state_r <= ST_EXTRA;
                            end
                            `PFM_WAIT_RDY: begin
                                busWait <= ~readyIn;
                                state_r <= readyIn ? ST_IDLE : ST_HOLD;
                            end
                            `PFM_WAIT_EXTRDY: begin
                                busWait <= 1'b1;
                                state_r <= readyIn ? ST_EXTRA : ST_HOLD;
                            end
                            default: begin
                                busWait <= 1'b0;
                                state_r <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_HOLD: begin
                    if (readyIn) begin
                        // extended scheme adds one cycle after ready returns
                        if (scheme == `PFM_WAIT_EXTRDY) begin
                            state_r <= ST_EXTRA;
                        end else begin
                            busWait <= 1'b0;
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_EXTRA: begin
                    busWait <= 1'b0;
                    state_r <= ST_IDLE;
                end
                default: begin
                    busWait <= 1'b0;
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> test_pfm_pin_function_mux.sv
// self-checking bench for the pin function mux
// assumes design, map header, far model and checker compile first
`include "pfm_map.vh"
module test_pfm_pin_function_mux;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, rst = 1, regWr = 0, regRd = 0, cpuWrEn = 0, cpuWrN = 1, cpuRdN = 1;
    logic cpuAccessStart = 0, cpuIndYLoadStore = 0, cpuBeyond64k = 0, fetchSync = 0;
    logic dmaActive = 0, timerXOutMode = 0, timerXOut = 0, timerYOutMode = 0, timerYOut = 0;
    logic timer1Toggle = 0, hostOutFullZero = 0, hostInFullZeroN = 1, hostOutFullOne = 0;
    logic hostInFullOneN = 1, busYieldAck = 0, usbFrameStart = 0, secondUartTx = 0;
    logic secondUartRequestToSend = 1, clockedSerialReadyOut = 0, clockedSerialReadyOe = 0;
    logic clockedSerialClkOut = 0, clockedSerialClkOe = 0, clockedSerialTx = 0, slow = 1;
    logic [7:0] regAddr = 0, regWrData = 0, cpuWrData = 0, hostRdData = 0;
    logic [15:0] cpuAddr = 0;
    logic [71:0] extIn = 72'h0;
    wire [7:0] regRdData, cpuRdData, hostWrData;
    wire [71:0] padIn, padOut, padOe, padSlew;
    wire busWait, keyWake, promVerify, promProgramStrobeN, promChipEnableN, promOutputEnableN;
    wire extIrqZero, extIrqOne, timerXIn, timerXIrq, timerYIn, timerYIrq, holdReq;
    wire hostBufferZeroSelectN, hostBufferOneSelectN, hostRegisterSelect, hostReadN, hostWriteN;
    wire secondUartRx, secondUartClearToSend, clockedSerialReadyIn, clockedSerialClkIn;
    wire clockedSerialRx;
    int failures = 0, n_checks = 0, n;
    pfm_pin_function_mux DUT (.*);
    pfm_far_model u_far (.clock(clock), .padOut(padOut), .padOe(padOe), .extIn(extIn),
        .accessStart(cpuAccessStart), .slow(slow), .padIn(padIn));
    initial forever #5 clock = ~clock;
    task automatic print_verdict;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp(input logic [71:0] got, input logic [71:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1;
        @(posedge clock);
        regWr <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1;
        @(posedge clock);
        regRd <= 0;
        #1 cmp(regRdData, e);
    endtask
    // counts high cycles of the wait request or the frame pin
    task automatic count(input bit w);
        n = 0;
        repeat (12) begin
            @(posedge clock);
            #1 n += w ? busWait : padOut[56];
        end
    endtask
    initial begin
        tick(10);
        rst <= 0;
        #1 cmp(padOe, 0);
        wr(`PFM_OFS_DIR, 8'hFF);
        wr(`PFM_OFS_DATA, 8'hA5);
        wr(`PFM_OFS_SLEW + 8'h08, 8'h3C);
        wr(`PFM_OFS_KEYMASK, 8'h01);
        tick(1);
        #1 cmp({padOe[7:0], padOut[7:0], padSlew[71:64]}, 24'hFFA53C);
        rd(`PFM_OFS_PIN, 8'hA5);
        rd(8'h50, 8'h00);
        cmp(keyWake, 1);
        tick(1);
        extIn[23:16] <= 8'hFF;
        tick(3);
        #1 cmp(keyWake, 0);
        for (int p = 0; p < 2; p++)
            for (int v = 0; v < 2; v++) begin
                wr(`PFM_OFS_CTRL1, 8'(p));
                extIn[33] <= v[0];
                tick(3);
                #1 cmp(extIrqZero, p == v);
            end
        // both serial owners enabled: the uart keeps the shared pins
        wr(`PFM_OFS_CTRL1, 8'h60);
        secondUartTx <= 1;
        extIn[65] <= 0;
        tick(3);
        #1 cmp({padOe[64], padOut[64], secondUartRx, clockedSerialRx}, 4'b1101);
        tick(1);
        timerXOutMode <= 1;
        timerXOut <= 1;
        extIn[36] <= 1;
        tick(3);
        #1 cmp({padOe[35], padOut[35], timerXIn, timerYIn}, 4'b1101);
        tick(1);
        timerYOutMode <= 1;
        timerYOut <= 1;
        tick(3);
        #1 cmp({padOe[36], padOut[36], timerYIrq}, 3'b110);
        wr(`PFM_OFS_CTRL0, 8'h40);
        usbFrameStart <= 1;
        tick(1);
        usbFrameStart <= 0;
        count(0);
        cmp(n, `PFM_SOF_PULSE_NS / 10);
        wr(`PFM_OFS_CTRL0, 8'h11);
        cpuIndYLoadStore <= 1;
        cpuBeyond64k <= 1;
        cpuAddr <= 16'hBEEF;
        cpuWrEn <= 1;
        cpuWrData <= 8'h5A;
        cpuWrN <= 0;
        dmaActive <= 1;
        fetchSync <= 1;
        tick(2);
        #1 cmp({padOut[31:29], padOut[27], padOut[23:0], padOe[23:0]},
            {4'b1011, 24'h5ABEEF, 24'hFFFFFF});
        cmp({padOut[32], padOe[32], cpuRdData}, {2'b11, 8'h5A});
        for (int s = 1; s < 4; s++) begin
            wr(`PFM_OFS_CTRL0, 8'(s * 4 + 1));
            cpuAccessStart <= 1;
            tick(1);
            cpuAccessStart <= 0;
            count(1);
            cmp(n, s == 1 ? 1 : s + 2);
        end
        // host port, prom pins and timer 1 output share no pad, so one setup covers all
        wr(`PFM_OFS_CTRL1, 8'hF0);
        wr(`PFM_OFS_CTRL0, 8'hA3);
        extIn[26] <= 1;
        hostRdData <= 8'hC3;
        hostInFullOneN <= 0;
        busYieldAck <= 1;
        tick(2);
        #1 cmp({padOe[41], padOut[41], promVerify, promProgramStrobeN, promOutputEnableN},
            5'b11100);
        cmp({padOe[55:48], padOut[55:48], hostWrData, padOut[59], hostReadN,
            hostBufferZeroSelectN}, {24'hFFC3C3, 3'b000});
        tick(1);
        timer1Toggle <= 1;
        tick(1);
        timer1Toggle <= 0;
        tick(1);
        #1 cmp(padOut[41], 0);
        print_verdict;
    end
    initial begin
        #20000;
        failures++;
        print_verdict;
    end
endmodule
